// *** rtl/oc_pkg.sv ***
// Summary of operation
// RULE1: The stages watch exactly one auxiliary current input, normal or high-sensitivity, as chosen.
// RULE2: With the high-sensitivity input chosen, thresholds go down to a 3 mA floor and no lower.
// RULE3: The chosen current passes a narrow-band filter before each threshold compare, except the raw-sample bypass of RULE7.
// RULE4: The high stage raises its pickup flag while the filtered current is above its threshold.
// RULE5: A high pickup that lasts the high delay issues the trip.
// RULE6: The high stage drops out near 95 % above rated current, and at a lower ratio (90 %) below.
// RULE7: A raw sample at 2 times root 2 of the high threshold or more bypasses the filter.
// RULE8: The low stage raises its pickup flag while the filtered current exceeds its threshold.
// RULE9: A low pickup that lasts the low delay issues the trip.
// RULE10: The low stage drops out near 95 % above rated current, and at a wider 80 % below.
// RULE11: Both stages run independently; an infinite threshold turns that stage off.
// RULE12: The function switch gives on, off or block; block keeps pickups but holds the trip off.
// RULE13: An infinite delay never trips yet still reports pickup; a zero delay trips at once.
// RULE14: A stage that drops out clears its timer; the trip is the OR of both stages.
package oc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] HIGH_THR_OFS = 8'h04;
  localparam logic [7:0] LOW_THR_OFS  = 8'h08;
  localparam logic [7:0] HIGH_DLY_OFS = 8'h0c;
  localparam logic [7:0] LOW_DLY_OFS  = 8'h10;
  localparam logic [7:0] STATE_OFS    = 8'h14;
  localparam logic [7:0] MAG_OFS      = 8'h18;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h1c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h20;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int          SW_LSB      = 0;
  localparam int          SENS_BIT    = 2;
  localparam logic [15:0] INF_VAL     = 16'hffff; // Infinity code
  localparam logic [15:0] THR_RST     = 16'hffff;
  localparam logic [15:0] DLY_RST     = 16'h0000;
  localparam logic [15:0] SENS_MIN    = 16'h0003; // 3 mA at 1 mA per LSB
  localparam logic [15:0] RATED_CODE  = 16'h1000; // Rated current code
  localparam logic [7:0]  DROP_HI     = 8'hf3;    // 243/256, about 95 %
  localparam logic [7:0]  DROP_HIGH_L = 8'he6;    // 230/256, about 90 %
  localparam logic [7:0]  DROP_LOW_L  = 8'hcd;    // 205/256, about 80 %
  localparam logic [6:0]  RT2_FRAC    = 7'h35;    // 53/64, 2*sqrt2 = 2+0.828
  localparam int          FILT_SHIFT  = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS    = 10;
  localparam int TICK_NS   = 1000000;  // Delay unit 1 ms
  localparam int TICK_CYC  = TICK_NS / CLK_NS;

  typedef enum logic [1:0] {
    SW_OFF   = 2'h0,
    SW_ON    = 2'h1,
    SW_BLOCK = 2'h2
  } func_sw_t;

endpackage : oc_pkg

// *** rtl/band_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module band_filter
  import oc_pkg::*;
#(
  parameter int W     = 16,
  parameter int SHIFT = FILT_SHIFT
) (
  input  wire logic         ref_clk_i,  // System clock
  input  wire logic         reset_i,    // Async reset
  input  wire logic         valid_i,    // New sample
  input  wire logic [W-1:0] abs_i,      // Rectified sample
  output logic      [W-1:0] mag_o       // Filtered magnitude
);

  logic [W+SHIFT-1:0] acc_ff;

  // ****************************************
  // Narrow first-order smoothing
  // ****************************************
  // Long time constant trades speed for noise rejection
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_ff <= '0;
    end else if (valid_i) begin
      acc_ff <= acc_ff - (W+SHIFT)'(acc_ff >> SHIFT) + (W+SHIFT)'(abs_i);
    end
  end

  assign mag_o = acc_ff[W+SHIFT-1:SHIFT];

endmodule : band_filter
`default_nettype wire

// *** rtl/oc_detector.sv ***
`timescale 1ns/1ns
`default_nettype none
module oc_detector
  import oc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        ref_clk_i,    // 100 MHz clock
  input  wire logic        reset_i,      // Async reset, high
  input  wire logic        hsel_i,       // AHB select
  input  wire logic [31:0] haddr_i,      // AHB address
  input  wire logic [1:0]  htrans_i,     // AHB transfer type
  input  wire logic        hwrite_i,     // AHB write
  input  wire logic [2:0]  hsize_i,      // AHB size
  input  wire logic [31:0] hwdata_i,     // AHB write data
  input  wire logic        hready_i,     // AHB ready in
  output logic             hreadyout_o,  // AHB ready out
  output logic             hresp_o,      // AHB response
  output logic      [31:0] hrdata_o,     // AHB read data
  input  wire logic        norm_vld_i,   // Normal input sample valid
  input  wire logic [15:0] norm_smp_i,   // Normal input sample
  input  wire logic        sens_vld_i,   // Sensitive input sample valid
  input  wire logic [15:0] sens_smp_i,   // Sensitive input sample
  output logic             high_pu_o,    // High stage pickup
  output logic             low_pu_o,     // Low stage pickup
  output logic             trip_o,       // Trip command
  output logic             irq_o         // Interrupt, level
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] abs16(input logic [15:0] s);
    logic [15:0] n;
    n = 16'h0000 - s;
    if (!s[15]) return s;
    if (s == 16'h8000) return 16'h7fff;
    return n;
  endfunction : abs16

  function automatic logic [15:0] drop_lvl(input logic [15:0] thr,
                                           input logic [7:0]  frac);
    logic [23:0] p;
    p = thr * frac;
    return p[23:8];
  endfunction : drop_lvl

  function automatic logic [15:0] floor_thr(input logic [15:0] thr,
                                            input logic        sens);
    if (sens && thr < SENS_MIN) return SENS_MIN;
    return thr;
  endfunction : floor_thr

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0]  fsw_ff;
  logic        sens_ff;
  logic [15:0] hthr_ff, lthr_ff, hdly_ff, ldly_ff;
  logic [3:0]  irq_stat_ff, irq_mask_ff;
  logic        wr_ff;
  logic [7:0]  wadr_ff;
  logic [31:0] hrdata_ff;
  logic        hpu_ff, lpu_ff, htrip_ff, ltrip_ff, trip_ff, byp_ff;
  logic [15:0] hcnt_ff, lcnt_ff;
  logic [$clog2(TICK_CYCLES+1)-1:0] pre_ff;
  logic        trip_d_ff;

  logic        acc, rd_acc, stat_rd;
  logic [7:0]  aadr;
  logic        smp_vld;
  logic [15:0] smp_abs, mag;
  logic [15:0] hthr, lthr, hdrop, ldrop;
  logic        hinf, linf, sw_run, tick;
  logic        nxt_htrip, nxt_ltrip;
  logic [18:0] byp_lim;
  logic [3:0]  ev;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Zero wait states; every access answers OKAY
  assign acc         = hsel_i && hready_i && htrans_i[1];
  assign rd_acc      = acc && !hwrite_i;
  assign aadr        = haddr_i[7:0];
  assign stat_rd     = rd_acc && aadr == IRQ_STAT_OFS;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_ff;

  // Address phase capture for the write data phase
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ff   <= 1'b0;
      wadr_ff <= 8'h00;
    end else begin
      wr_ff   <= acc && hwrite_i;
      wadr_ff <= aadr;
    end
  end

  // Read data latched in address phase, stable in data phase
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_acc) begin
      unique case (aadr)
        CTRL_OFS:     hrdata_ff <= {29'h0, sens_ff, fsw_ff};
        HIGH_THR_OFS: hrdata_ff <= {16'h0, hthr_ff};
        LOW_THR_OFS:  hrdata_ff <= {16'h0, lthr_ff};
        HIGH_DLY_OFS: hrdata_ff <= {16'h0, hdly_ff};
        LOW_DLY_OFS:  hrdata_ff <= {16'h0, ldly_ff};
        STATE_OFS:    hrdata_ff <= {26'h0, byp_ff, trip_ff, ltrip_ff,
                                    htrip_ff, lpu_ff, hpu_ff};
        MAG_OFS:      hrdata_ff <= {16'h0, mag};
        IRQ_STAT_OFS: hrdata_ff <= {28'h0, irq_stat_ff};
        IRQ_MASK_OFS: hrdata_ff <= {28'h0, irq_mask_ff};
        default:      hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Settings written in the data phase
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fsw_ff      <= SW_OFF;
      sens_ff     <= 1'b0;
      hthr_ff     <= THR_RST;
      lthr_ff     <= THR_RST;
      hdly_ff     <= DLY_RST;
      ldly_ff     <= DLY_RST;
      irq_mask_ff <= 4'h0;
    end else if (wr_ff) begin
      unique case (wadr_ff)
        CTRL_OFS: begin
          fsw_ff  <= hwdata_i[SW_LSB+:2];
          sens_ff <= hwdata_i[SENS_BIT];
        end
        HIGH_THR_OFS: hthr_ff     <= hwdata_i[15:0];
        LOW_THR_OFS:  lthr_ff     <= hwdata_i[15:0];
        HIGH_DLY_OFS: hdly_ff     <= hwdata_i[15:0];
        LOW_DLY_OFS:  ldly_ff     <= hwdata_i[15:0];
        IRQ_MASK_OFS: irq_mask_ff <= hwdata_i[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Input selection and filter
  // ****************************************
  // Only the chosen input feeds the filter and bypass
  assign smp_vld = sens_ff ? sens_vld_i : norm_vld_i;                 // RULE1
  assign smp_abs = abs16(sens_ff ? sens_smp_i : norm_smp_i);          // RULE1

  band_filter #(
    .W     (16),
    .SHIFT (FILT_SHIFT)
  ) u_filt (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .valid_i   (smp_vld),
    .abs_i     (smp_abs),
    .mag_o     (mag)                                                  // RULE3
  );

  // ****************************************
  // Thresholds and dropout levels
  // ****************************************
  assign hthr   = floor_thr(hthr_ff, sens_ff);                        // RULE2
  assign lthr   = floor_thr(lthr_ff, sens_ff);                        // RULE2
  assign hinf   = hthr_ff == INF_VAL;                                 // RULE11
  assign linf   = lthr_ff == INF_VAL;                                 // RULE11
  assign sw_run = fsw_ff == SW_ON || fsw_ff == SW_BLOCK;              // RULE12
  // Wider hysteresis at low current stops chatter near the setting
  assign hdrop  = drop_lvl(hthr, hthr >= RATED_CODE ? DROP_HI : DROP_HIGH_L); // RULE6
  assign ldrop  = drop_lvl(lthr, lthr >= RATED_CODE ? DROP_HI : DROP_LOW_L);  // RULE10
  // 2*sqrt2 approximated as 2 + 53/64
  assign byp_lim = {2'b00, hthr, 1'b0} + 19'(({8'h00, hthr} * RT2_FRAC) >> 6); // RULE7

  // Raw sample bypass flag, refreshed each sample
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byp_ff <= 1'b0;
    end else if (smp_vld) begin
      byp_ff <= !hinf && {3'b000, smp_abs} >= byp_lim;                // RULE7
    end
  end

  // ****************************************
  // Pickup with hysteresis
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hpu_ff <= 1'b0;
    end else if (!sw_run || hinf) begin
      hpu_ff <= 1'b0;                                                 // RULE11
    end else if (byp_ff || mag > hthr) begin
      hpu_ff <= 1'b1;                                                 // RULE4
    end else if (mag < hdrop) begin
      hpu_ff <= 1'b0;                                                 // RULE6
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lpu_ff <= 1'b0;
    end else if (!sw_run || linf) begin
      lpu_ff <= 1'b0;                                                 // RULE11
    end else if (mag > lthr) begin
      lpu_ff <= 1'b1;                                                 // RULE8
    end else if (mag < ldrop) begin
      lpu_ff <= 1'b0;                                                 // RULE10
    end
  end

  // ****************************************
  // Delay timers
  // ****************************************
  // Shared 1 ms prescaler; first tick may come early by under 1 ms
  assign tick = pre_ff == '0;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_ff <= '0;
    end else if (tick) begin
      pre_ff <= ($bits(pre_ff))'(TICK_CYCLES - 1);
    end else begin
      pre_ff <= pre_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hcnt_ff <= 16'h0000;
    end else if (!hpu_ff) begin
      hcnt_ff <= 16'h0000;                                            // RULE14
    end else if (tick && hcnt_ff != INF_VAL) begin
      hcnt_ff <= hcnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lcnt_ff <= 16'h0000;
    end else if (!lpu_ff) begin
      lcnt_ff <= 16'h0000;                                            // RULE14
    end else if (tick && lcnt_ff != INF_VAL) begin
      lcnt_ff <= lcnt_ff + 16'h0001;
    end
  end

  // ****************************************
  // Trip decision
  // ****************************************
  // Infinite delay never trips; zero delay trips on pickup
  assign nxt_htrip = hpu_ff && hdly_ff != INF_VAL && hcnt_ff >= hdly_ff; // RULE5 RULE13
  assign nxt_ltrip = lpu_ff && ldly_ff != INF_VAL && lcnt_ff >= ldly_ff; // RULE9 RULE13

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      htrip_ff <= 1'b0;
      ltrip_ff <= 1'b0;
      trip_ff  <= 1'b0;
    end else begin
      htrip_ff <= nxt_htrip;
      ltrip_ff <= nxt_ltrip;
      // Block keeps stage trips visible but holds the relay off
      trip_ff  <= (nxt_htrip || nxt_ltrip) && fsw_ff == SW_ON;        // RULE12 RULE14
    end
  end

  assign high_pu_o = hpu_ff;
  assign low_pu_o  = lpu_ff;
  assign trip_o    = trip_ff;

  // ****************************************
  // Interrupts
  // ****************************************
  // Events: high pickup, low pickup, trip rise, bypass pickup (bypass while the high stage is not yet picked up)
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      trip_d_ff <= 1'b0;
    end else begin
      trip_d_ff <= trip_ff;
    end
  end

  assign ev = {byp_ff && !hpu_ff && sw_run, trip_ff && !trip_d_ff,
               mag > lthr && !lpu_ff && sw_run && !linf,
               (byp_ff || mag > hthr) && !hpu_ff && sw_run && !hinf};

  // Read clears; a same-cycle event is kept
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat_ff <= 4'h0;
    end else begin
      irq_stat_ff <= (stat_rd ? 4'h0 : irq_stat_ff) | ev;
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  input_sel_a: assert property ( // RULE1
    sens_ff && !sens_vld_i |=> $stable(mag))
    else $error("sensitive input not selected");

  sens_floor_a: assert property ( // RULE2
    sens_ff |-> hthr >= SENS_MIN && lthr >= SENS_MIN)
    else $error("sensitive threshold below floor");

  high_pickup_a: assert property ( // RULE4
    sw_run && !hinf && mag > hthr |=> hpu_ff)
    else $error("high pickup missed");

  high_trip_a: assert property ( // RULE5
    hpu_ff && hdly_ff == 16'h0000 && fsw_ff == SW_ON |=> trip_o)
    else $error("undelayed high trip missed");

  high_hold_a: assert property ( // RULE6
    hpu_ff && sw_run && !hinf && mag >= hdrop |=> hpu_ff)
    else $error("high stage dropped above dropout");

  bypass_pick_a: assert property ( // RULE7
    byp_ff && sw_run && !hinf |=> hpu_ff)
    else $error("bypass did not pick up");

  low_pickup_a: assert property ( // RULE8
    sw_run && !linf && mag > lthr |=> lpu_ff ##0 low_pu_o)
    else $error("low pickup missed");

  low_trip_a: assert property ( // RULE9
    lpu_ff && ldly_ff != INF_VAL && lcnt_ff >= ldly_ff |=> ltrip_ff)
    else $error("low trip missed");

  low_drop_a: assert property ( // RULE10
    lpu_ff && sw_run && !linf && mag < ldrop |=> !lpu_ff)
    else $error("low stage failed to drop out");

  stage_off_a: assert property ( // RULE11
    hinf && linf |=> !hpu_ff && !lpu_ff)
    else $error("disabled stage picked up");

  block_trip_a: assert property ( // RULE12
    fsw_ff != SW_ON |=> !trip_o)
    else $error("trip while not switched on");

  inf_delay_a: assert property ( // RULE13
    hdly_ff == INF_VAL && ldly_ff == INF_VAL |=> !htrip_ff && !ltrip_ff)
    else $error("trip with infinite delay");

  timer_clear_a: assert property ( // RULE14
    !hpu_ff && !lpu_ff |=> hcnt_ff == 16'h0000 && lcnt_ff == 16'h0000)
    else $error("timer not cleared on dropout");

endmodule : oc_detector
`default_nettype wire

// *** tb/cur_front_end.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Current front end and trip relay model
// ****************************************
module cur_front_end #(
  parameter int SPACING = 4  // Cycles between samples
) (
  input  wire logic signed [15:0] norm_amp_i,  // Normal input amplitude
  input  wire logic signed [15:0] sens_amp_i,  // Sensitive input amplitude
  input  wire logic               ref_clk_i,   // System clock
  input  wire logic               reset_i,     // Async reset
  input  wire logic               trip_i,      // Trip command
  output logic                    norm_vld_o,  // Normal sample valid
  output logic             [15:0] norm_smp_o,  // Normal sample
  output logic                    sens_vld_o,  // Sensitive sample valid
  output logic             [15:0] sens_smp_o,  // Sensitive sample
  output logic                    contact_o    // Relay contact closed
);
  int   phase_ff;
  logic neg_ff;
  // Alternating sign; data lines scramble between valids so a stale value never helps
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_ff   <= 0;
      neg_ff     <= 1'b0;
      norm_vld_o <= 1'b0;
      sens_vld_o <= 1'b0;
      norm_smp_o <= 16'h0000;
      sens_smp_o <= 16'h0000;
    end else begin
      phase_ff   <= (phase_ff == SPACING - 1) ? 0 : phase_ff + 1;
      neg_ff     <= (phase_ff == SPACING - 1) ? ~neg_ff : neg_ff;
      norm_vld_o <= (phase_ff == 0);
      sens_vld_o <= (phase_ff == SPACING / 2);
      norm_smp_o <= (phase_ff == 0) ? (neg_ff ? -norm_amp_i : norm_amp_i) : ~norm_smp_o;
      sens_smp_o <= (phase_ff == SPACING / 2) ? (neg_ff ? -sens_amp_i : sens_amp_i) : ~sens_smp_o;
    end
  end
  // Relay armature lags the coil by one cycle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      contact_o <= 1'b0;
    end else begin
      contact_o <= trip_i;
    end
  end
endmodule : cur_front_end
`default_nettype wire

// *** tb/tb_two_stage_definite_time_overcurrent.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_two_stage_definite_time_overcurrent;
  import oc_pkg::*;
  localparam int TK = 10;  // Short ms tick keeps the run brief
  localparam logic [7:0] RA [9] = '{CTRL_OFS, HIGH_THR_OFS, LOW_THR_OFS, HIGH_DLY_OFS,
    LOW_DLY_OFS, STATE_OFS, MAG_OFS, IRQ_MASK_OFS, 8'h40};
  localparam logic [31:0] RV [9] = '{32'h0, {16'h0, THR_RST}, {16'h0, THR_RST},
    {16'h0, DLY_RST}, {16'h0, DLY_RST}, 32'h0, 32'h0, 32'h0, 32'h0};
  // Hysteresis rows: stage, threshold, pickup, hold and release amplitudes
  localparam bit HS [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  localparam int TH [4] = '{2000, 2000, 8000, 8000};
  localparam int AON [4] = '{2600, 2600, 9500, 9500};
  localparam int AHD [4] = '{1900, 1700, 7800, 7800};
  localparam int AOF [4] = '{1700, 1300, 7300, 7300};
  logic               ref_clk_i;
  logic               reset_i;
  logic [1:0]         htrans;
  logic [31:0]        haddr;
  logic               hwrite;
  logic [31:0]        hwdata;
  logic [31:0]        rd;
  logic signed [15:0] norm_amp;
  logic signed [15:0] sens_amp;
  wire logic          hready;
  wire logic          hresp;
  wire logic [31:0]   hrdata;
  wire logic          norm_vld;
  wire logic          sens_vld;
  wire logic [15:0]   norm_smp;
  wire logic [15:0]   sens_smp;
  wire logic          high_pu;
  wire logic          low_pu;
  wire logic          trip;
  wire logic          irq;
  wire logic          contact;
  int                 errors;
  int                 checked;

  oc_detector #(.TICK_CYCLES(TK)) i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .norm_vld_i(norm_vld), .norm_smp_i(norm_smp), .sens_vld_i(sens_vld),
    .sens_smp_i(sens_smp), .high_pu_o(high_pu), .low_pu_o(low_pu), .trip_o(trip),
    .irq_o(irq));
  cur_front_end i_front (.norm_amp_i(norm_amp), .sens_amp_i(sens_amp), .ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .trip_i(trip), .norm_vld_o(norm_vld), .norm_smp_o(norm_smp),
    .sens_vld_o(sens_vld), .sens_smp_o(sens_smp), .contact_o(contact));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val
  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_rng
  // One single word transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic set_amp(input int n, input int s);
    @(posedge ref_clk_i);
    norm_amp <= 16'(n);
    sens_amp <= 16'(s);
  endtask : set_amp
  // Bounded wait for a pickup level, then compare it
  task automatic wait_pu(input bit hi, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((hi ? high_pu : low_pu) !== lvl && n < lim) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check_val(hi ? "high_pu" : "low_pu", {31'h0, lvl}, {31'h0, hi ? high_pu : low_pu});
  endtask : wait_pu
  // Cycles from pickup to trip, against the delay window
  task automatic measure(input bit hi, input int dly);
    int n;
    wait_pu(hi, 1'b1, 4000);
    n = 0;
    while (trip !== 1'b1 && n < dly * TK + 50) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check_rng("trip_delay", (dly - 1) * TK, dly * TK + 3, n);
  endtask : measure
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // Clock, watchdog and test sequence
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Whole sequence needs about 8000 cycles
  initial begin
    #600000;
    errors++;
    $display("[ERR] watchdog expected end seen hang");
    finish_test();
  end
  initial begin
    reset_i = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    norm_amp = 16'sh0000;
    sens_amp = 16'sh0000;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // Reset values; read-only and unmapped places ignore writes
    ahb(1'b1, 8'h40, 32'hffffffff);
    ahb(1'b1, STATE_OFS, 32'hffffffff);
    for (int i = 0; i < 9; i++) begin
      ahb(1'b0, RA[i], 32'h0);
      check_val($sformatf("reg_%h", RA[i]), RV[i], rd);
    end
    check_val("hresp", 32'h0, {31'h0, hresp});
    $display("Test registers finished");
    // Large raw sample skips the filter; zero delay trips at once
    ahb(1'b1, HIGH_THR_OFS, 32'h03e8);
    ahb(1'b1, CTRL_OFS, 32'(SW_ON));
    set_amp(3000, 0);
    do @(posedge ref_clk_i);
    while (!(norm_vld === 1'b1 && (norm_smp === 16'h0bb8 || norm_smp === 16'hf448)));
    repeat (1) @(posedge ref_clk_i);
    #1;
    check_val("high_pu", 32'h1, {31'h0, high_pu});
    check_val("trip", 32'h0, {31'h0, trip});
    @(posedge ref_clk_i);
    #1;
    check_val("trip", 32'h1, {31'h0, trip});
    check_val("irq", 32'h0, {31'h0, irq});
    set_amp(0, 0);
    wait_pu(1'b1, 1'b0, 4000);
    @(posedge ref_clk_i);
    #1;
    check_val("trip", 32'h0, {31'h0, trip});
    ahb(1'b1, IRQ_MASK_OFS, 32'h0000000f);
    #1;
    check_val("irq", 32'h1, {31'h0, irq});
    ahb(1'b0, IRQ_STAT_OFS, 32'h0);
    check_val("irq_stat", 32'h0000000d, rd);
    #1;
    check_val("irq", 32'h0, {31'h0, irq});
    ahb(1'b0, IRQ_STAT_OFS, 32'h0);
    check_val("irq_stat", 32'h0, rd);
    // Block keeps the stage working but holds the trip output low
    ahb(1'b1, CTRL_OFS, 32'(SW_BLOCK));
    set_amp(3000, 0);
    wait_pu(1'b1, 1'b1, 200);
    repeat (20) @(posedge ref_clk_i);
    ahb(1'b0, STATE_OFS, 32'h0);
    check_val("state", 32'h00000005, rd & 32'h00000017);
    check_val("trip", 32'h0, {31'h0, trip});
    ahb(1'b1, CTRL_OFS, 32'(SW_OFF));
    wait_pu(1'b1, 1'b0, 50);
    set_amp(0, 0);
    $display("Test bypass_irq_block finished");
    // Dropout ratios per stage and current range, infinite delays
    ahb(1'b1, HIGH_DLY_OFS, 32'h0000ffff);
    ahb(1'b1, LOW_DLY_OFS, 32'h0000ffff);
    ahb(1'b1, CTRL_OFS, 32'(SW_ON));
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, HIGH_THR_OFS, HS[i] ? 32'(TH[i]) : 32'h0000ffff);
      ahb(1'b1, LOW_THR_OFS, HS[i] ? 32'h0000ffff : 32'(TH[i]));
      set_amp(AON[i], 0);
      wait_pu(HS[i], 1'b1, 4000);
      set_amp(AHD[i], 0);
      repeat (1200) @(posedge ref_clk_i);
      #1;
      check_val("held_pu", 32'h1, {31'h0, HS[i] ? high_pu : low_pu});
      check_val("other_pu", 32'h0, {31'h0, HS[i] ? low_pu : high_pu});
      check_val("trip", 32'h0, {31'h0, trip});
      ahb(1'b0, MAG_OFS, 32'h0);
      check_rng("mag", AHD[i] - 15, AHD[i] + 15, int'(rd));
      set_amp(AOF[i], 0);
      wait_pu(HS[i], 1'b0, 4000);
    end
    $display("Test hysteresis finished");
    // Timed trips; a dropout restarts the low stage timer
    ahb(1'b1, LOW_THR_OFS, 32'h0000ffff);
    ahb(1'b1, HIGH_THR_OFS, 32'h00000bb8);
    ahb(1'b1, HIGH_DLY_OFS, 32'h00000002);
    set_amp(4000, 0);
    measure(1'b1, 2);
    set_amp(0, 0);
    wait_pu(1'b1, 1'b0, 4000);
    @(posedge ref_clk_i);
    #1;
    check_val("trip", 32'h0, {31'h0, trip});
    ahb(1'b1, HIGH_THR_OFS, 32'h0000ffff);
    ahb(1'b1, LOW_THR_OFS, 32'h000003e8);
    ahb(1'b1, LOW_DLY_OFS, 32'h0000001e);
    set_amp(2000, 0);
    wait_pu(1'b0, 1'b1, 4000);
    repeat (150) @(posedge ref_clk_i);
    set_amp(0, 0);
    wait_pu(1'b0, 1'b0, 4000);
    check_val("trip", 32'h0, {31'h0, trip});
    set_amp(2000, 0);
    measure(1'b0, 30);
    set_amp(0, 0);
    wait_pu(1'b0, 1'b0, 4000);
    $display("Test timers finished");
    // Only the chosen input is measured
    ahb(1'b1, LOW_THR_OFS, {16'h0, SENS_MIN});
    ahb(1'b1, LOW_DLY_OFS, 32'h0000ffff);
    ahb(1'b1, CTRL_OFS, 32'(SW_ON) | (32'h1 << SENS_BIT));
    set_amp(20000, 0);
    repeat (1200) @(posedge ref_clk_i);
    #1;
    check_val("low_pu", 32'h0, {31'h0, low_pu});
    set_amp(20000, 40);
    wait_pu(1'b0, 1'b1, 4000);
    ahb(1'b1, CTRL_OFS, 32'(SW_ON));
    ahb(1'b1, LOW_THR_OFS, 32'h000003e8);
    set_amp(0, 20000);
    wait_pu(1'b0, 1'b0, 4000);
    repeat (400) @(posedge ref_clk_i);
    #1;
    check_val("low_pu", 32'h0, {31'h0, low_pu});
    $display("Test input_select finished");
    finish_test();
  end
endmodule : tb_two_stage_definite_time_overcurrent
`default_nettype wire
